/* src/aodf_regs.vh */
// Constants for the converter output demultiplexer and formatter
`ifndef AODF_REGS_VH
`define AODF_REGS_VH

// Width of one converter code
`define AODF_CODE_W 8
// Position of the code sign bit, inverted for offset binary
`define AODF_CODE_MSB 7
// Number of converter channels
`define AODF_CHANNELS 2
// Buffer word: {edge parity, q code, i code}
`define AODF_WORD_W 17
`define AODF_WORD_PARITY 16
// Buffer depth and its pointer width
`define AODF_BUF_DEPTH 2
`define AODF_PTR_W 1
`define AODF_CNT_W 2
// Width of the pin synchroniser: edge, ddr, shutdown x2, ready, q, i
`define AODF_PIN_W 21
// Falling sample clock edges needed before the block is armed
`define AODF_ARM_EDGES 3'h2
`define AODF_ARM_W 3
// Word pairs discarded after a channel wakes up
`define AODF_FLUSH_PAIRS 3'h4
`define AODF_FLUSH_W 3

`endif

/* src/aodf_pair_buffer.v */
// Two-entry valid/ready buffer between capture and output stage
`timescale 1ns/100ps
`include "aodf_regs.vh"

module aodf_pair_buffer
(
  input wire clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [`AODF_WORD_W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [`AODF_WORD_W-1:0] out_data
);

  localparam WIDTH = `AODF_WORD_W;
  // Sized to the occupancy counter so the full test compares like widths
  localparam [`AODF_CNT_W-1:0] DEPTH = `AODF_BUF_DEPTH;

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [`AODF_PTR_W-1:0] wr_ptr;
  reg [`AODF_PTR_W-1:0] rd_ptr;
  reg [`AODF_CNT_W-1:0] count;
  wire push;
  wire pop;

  // Honest full and empty flags
  assign in_ready = (count != DEPTH);
  assign out_valid = (count != {`AODF_CNT_W{1'b0}});
  assign out_data = store[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and occupancy bookkeeping
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= {`AODF_PTR_W{1'b0}};
      rd_ptr <= {`AODF_PTR_W{1'b0}};
      count <= {`AODF_CNT_W{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

  // Storage needs no reset; nothing reads an empty slot
  always @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

endmodule // aodf_pair_buffer

/* src/aodf_output_formatter.v */
// Output demultiplexer, offset-binary formatter and forwarded clock
//
// Notes on behaviour
// - Words started on odd falling sample edges go to the odd bus, even ones to the even bus.
// - Each bus carries half the sample rate and the receiver merges both buses of a channel.
// - One forwarded clock serves as latch reference for all four buses.
// - In single-edge mode the edge select picks which clock edge the data changes on.
// - In double-data-rate mode a word is presented on every clock edge at a quarter rate.
// - Codes are offset binary, so zero input toggles between 127 and 128.
// - State is reset asynchronously without clock edges; only capture waits for two falling sample clock edges.
// - Edge select high changes data on the rising clock edge, low on the falling edge.
// - A shut-down channel floats its buses and flushes stale pipeline words on wake-up.
`timescale 1ns/100ps
`include "aodf_regs.vh"

module aodf_output_formatter
(
  input wire clk,
  input wire reset,
  input wire sample_clock,
  input wire [`AODF_CODE_W-1:0] code_i,
  input wire [`AODF_CODE_W-1:0] code_q,
  input wire output_edge_select,
  input wire ddr_select,
  input wire shutdown_input_i,
  input wire shutdown_input_q,
  input wire receiver_ready,
  output wire capture_ready,
  output wire [`AODF_CODE_W-1:0] bus_odd_i,
  output wire [`AODF_CODE_W-1:0] bus_even_i,
  output wire [`AODF_CODE_W-1:0] bus_odd_q,
  output wire [`AODF_CODE_W-1:0] bus_even_q,
  output wire bus_i_oe_n,
  output wire bus_q_oe_n,
  output reg forwarded_output_clock
);

  ////////////////////////////////////////////////////////////////////////
  // Offset binary: flip the sign bit of a two's complement code
  function [`AODF_CODE_W-1:0] offset_binary;
    input [`AODF_CODE_W-1:0] code;
    begin
      offset_binary = {~code[`AODF_CODE_MSB], code[`AODF_CODE_MSB-1:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for every pin from outside this clock
  reg [`AODF_PIN_W-1:0] pin_meta;
  reg [`AODF_PIN_W-1:0] pin_sync;
  reg clk_meta;
  reg clk_sync;
  reg clk_last;
  wire [`AODF_PIN_W-1:0] pin_raw;
  wire edge_sel;
  wire ddr_mode;
  wire [`AODF_CHANNELS-1:0] shutdown;
  wire rx_ready;
  wire [`AODF_CODE_W-1:0] sync_q;
  wire [`AODF_CODE_W-1:0] sync_i;
  wire fall_edge;

  assign pin_raw = {output_edge_select, ddr_select, shutdown_input_q,
                    shutdown_input_i, receiver_ready, code_q, code_i};
  assign {edge_sel, ddr_mode, shutdown, rx_ready, sync_q, sync_i} = pin_sync;

  // Codes are synced bitwise; they must hold steady around the
  // falling edge, which a slow sample clock guarantees
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= {`AODF_PIN_W{1'b0}};
      pin_sync <= {`AODF_PIN_W{1'b0}};
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_last <= 1'b0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_meta <= sample_clock;
      clk_sync <= clk_meta;
      clk_last <= clk_sync;
    end
  end

  // Falling sample clock edge seen only behind the second flop
  assign fall_edge = clk_last & ~clk_sync;

  ////////////////////////////////////////////////////////////////////////
  // Arming: nothing is captured until the sample clock has run
  reg [`AODF_ARM_W-1:0] arm_count;
  wire armed;

  assign armed = (arm_count == `AODF_ARM_EDGES);

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      arm_count <= {`AODF_ARM_W{1'b0}};
    else if (fall_edge & ~armed)
      arm_count <= arm_count + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture: tag each falling edge as odd or even, format, buffer
  reg edge_parity;
  reg pair_open;
  wire cap_valid;
  wire [`AODF_WORD_W-1:0] cap_word;
  wire buf_valid;
  wire buf_ready;
  wire [`AODF_WORD_W-1:0] buf_word;

  // First edge after arming counts as odd
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      edge_parity <= 1'b1;
      pair_open <= 1'b0;
    end
    else if (fall_edge & armed)
    begin
      edge_parity <= ~edge_parity;
      pair_open <= edge_parity & capture_ready;
    end
  end

  // An even word whose odd partner was refused would pair with a stale
  // odd word further down, so that even word is skipped as well
  assign cap_valid = fall_edge & armed & (edge_parity | pair_open);
  assign cap_word = {edge_parity, offset_binary(sync_q),
                     offset_binary(sync_i)};

  // A full buffer drops the new sample; capture_ready shows it
  aodf_pair_buffer u_buffer
  (
    .clk(clk),
    .reset(reset),
    .in_valid(cap_valid),
    .in_ready(capture_ready),
    .in_data(cap_word),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pairing: hold the odd word, release both on the even word
  reg [`AODF_WORD_W-2:0] held_odd;
  reg held_valid;
  wire pop;
  wire pop_odd;
  wire pair_update;

  // Receiver stall backs up the buffer instead of losing words
  assign buf_ready = rx_ready;
  assign pop = buf_valid & buf_ready;
  assign pop_odd = pop & buf_word[`AODF_WORD_PARITY];
  // An even word with no odd partner is discarded to keep pairing
  assign pair_update = pop & ~buf_word[`AODF_WORD_PARITY] & held_valid;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      held_odd <= {(`AODF_WORD_W-1){1'b0}};
      held_valid <= 1'b0;
    end
    else if (pop_odd)
    begin
      held_odd <= buf_word[`AODF_WORD_W-2:0];
      held_valid <= 1'b1;
    end
    else if (pop)
      held_valid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Forwarded clock, one for all buses
  // Single edge: the update edge follows edge_sel, the return edge
  // comes with the next odd word, so the clock runs at half word rate
  // Edge select and mode act as straps: change them just after a pair
  // update, or one pair may go out without a clock edge
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      forwarded_output_clock <= 1'b0;
    else if (ddr_mode)
    begin
      if (pair_update)
        forwarded_output_clock <= ~forwarded_output_clock;
    end
    else if (pair_update)
      forwarded_output_clock <= edge_sel;
    else if (pop_odd)
      forwarded_output_clock <= ~edge_sel;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel buses, shutdown and wake-up flush
  wire [`AODF_CHANNELS*`AODF_CODE_W-1:0] odd_flat;
  wire [`AODF_CHANNELS*`AODF_CODE_W-1:0] even_flat;
  wire [`AODF_CHANNELS*`AODF_CODE_W-1:0] even_src;

  assign even_src = buf_word[`AODF_WORD_W-2:0];

  genvar ch;
  generate
    for (ch = 0; ch < `AODF_CHANNELS; ch = ch + 1)
    begin : g_chan
      reg [`AODF_CODE_W-1:0] odd_bus;
      reg [`AODF_CODE_W-1:0] even_bus;
      reg [`AODF_FLUSH_W-1:0] flush;

      // Words from before a shutdown are stale; skip a few pairs
      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          odd_bus <= {`AODF_CODE_W{1'b0}};
          even_bus <= {`AODF_CODE_W{1'b0}};
          flush <= {`AODF_FLUSH_W{1'b0}};
        end
        else if (shutdown[ch])
        begin
          odd_bus <= {`AODF_CODE_W{1'b0}};
          even_bus <= {`AODF_CODE_W{1'b0}};
          flush <= `AODF_FLUSH_PAIRS;
        end
        else if (pair_update)
        begin
          if (flush != {`AODF_FLUSH_W{1'b0}})
            flush <= flush - 1'b1;
          else
          begin
            // Both halves change on the same clock event
            odd_bus <= held_odd[ch*`AODF_CODE_W +: `AODF_CODE_W];
            even_bus <= even_src[ch*`AODF_CODE_W +: `AODF_CODE_W];
          end
        end
      end

      assign odd_flat[ch*`AODF_CODE_W +: `AODF_CODE_W] = odd_bus;
      assign even_flat[ch*`AODF_CODE_W +: `AODF_CODE_W] = even_bus;
    end
  endgenerate

  assign bus_odd_i = odd_flat[`AODF_CODE_W-1:0];
  assign bus_even_i = even_flat[`AODF_CODE_W-1:0];
  assign bus_odd_q = odd_flat[`AODF_CHANNELS*`AODF_CODE_W-1:`AODF_CODE_W];
  assign bus_even_q = even_flat[`AODF_CHANNELS*`AODF_CODE_W-1:`AODF_CODE_W];
  // Enables are low while driving; shutdown floats the channel
  assign bus_i_oe_n = shutdown[0];
  assign bus_q_oe_n = shutdown[1];

endmodule // aodf_output_formatter

/* verification/aodf_output_formatter_asserts.sv */
// Port checker for the output demultiplexer and formatter
`timescale 1ns/100ps
`include "aodf_regs.vh"

module aodf_checker
(
  input wire clk,
  input wire reset,
  input wire output_edge_select,
  input wire ddr_select,
  input wire shutdown_input_i,
  input wire capture_ready,
  input wire [`AODF_CODE_W-1:0] bus_odd_i,
  input wire [`AODF_CODE_W-1:0] bus_even_i,
  input wire [`AODF_CODE_W-1:0] bus_even_q,
  input wire bus_i_oe_n,
  input wire bus_q_oe_n,
  input wire forwarded_output_clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  property p_reset_vals;
    $fell(reset) |-> !forwarded_output_clock && capture_ready
      && bus_odd_i == 8'h00 && !bus_i_oe_n;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("state after reset wrong");
  // Arming takes several sample edges, so buses stay quiet
  property p_arm_quiet;
    $fell(reset) |-> (bus_even_i == 8'h00)[*8];
  endproperty
  a_arm_quiet: assert property (p_arm_quiet)
    else $error("bus moved before arming");
  property p_i_oe;
    $stable(shutdown_input_i)[*4] |-> bus_i_oe_n == shutdown_input_i;
  endproperty
  a_i_oe: assert property (p_i_oe)
    else $error("i enable does not follow shutdown");
  property p_i_float;
    bus_i_oe_n && $past(bus_i_oe_n)
      |-> bus_odd_i == 8'h00 && bus_even_i == 8'h00;
  endproperty
  a_i_float: assert property (p_i_float)
    else $error("i buses not cleared in shutdown");
  property p_i_clk;
    $changed(bus_even_i) && !bus_i_oe_n && !$past(bus_i_oe_n)
      |-> $changed(forwarded_output_clock);
  endproperty
  a_i_clk: assert property (p_i_clk)
    else $error("i bus moved without clock edge");
  property p_q_clk;
    $changed(bus_even_q) && !bus_q_oe_n && !$past(bus_q_oe_n)
      |-> $changed(forwarded_output_clock);
  endproperty
  a_q_clk: assert property (p_q_clk)
    else $error("q bus moved without clock edge");
  // Data edge must match the settled edge choice
  property p_sdr_edge;
    (!ddr_select && $stable(output_edge_select))[*4] ##0
      ($changed(bus_even_q) && !bus_q_oe_n && !$past(bus_q_oe_n))
      |-> forwarded_output_clock == output_edge_select;
  endproperty
  a_sdr_edge: assert property (p_sdr_edge)
    else $error("data changed on wrong clock edge");
  property p_ddr_hold;
    ddr_select[*4] ##0 $changed(forwarded_output_clock)
      |=> $stable(forwarded_output_clock)[*5];
  endproperty
  a_ddr_hold: assert property (p_ddr_hold)
    else $error("double rate clock too fast");
  c_stall: cover property (!capture_ready);
  c_ddr: cover property (ddr_select && $changed(forwarded_output_clock));
  c_wake: cover property ($fell(bus_i_oe_n));
endmodule // aodf_checker

bind aodf_output_formatter aodf_checker i_chk (.clk(clk), .reset(reset),
  .output_edge_select(output_edge_select), .ddr_select(ddr_select),
  .shutdown_input_i(shutdown_input_i), .capture_ready(capture_ready),
  .bus_odd_i(bus_odd_i), .bus_even_i(bus_even_i), .bus_even_q(bus_even_q),
  .bus_i_oe_n(bus_i_oe_n), .bus_q_oe_n(bus_q_oe_n),
  .forwarded_output_clock(forwarded_output_clock));

/* verification/aodf_rx_model.sv */
// Receiving logic that latches and merges the sample buses
`timescale 1ns/100ps

module aodf_rx_model
(
  input wire clk,
  input wire reset,
  input wire stall,
  input wire fwd_clk,
  input wire edge_sel,
  input wire ddr,
  input wire [7:0] odd_i,
  input wire [7:0] even_i,
  input wire [7:0] odd_q,
  input wire [7:0] even_q,
  output wire ready,
  output reg got,
  output reg [15:0] pair_i,
  output reg [15:0] pair_q
);
  reg last;
  // Quiet edge in single-edge mode, every edge in double rate
  wire latch = (fwd_clk != last) && (ddr || fwd_clk != edge_sel);
  assign ready = !stall;
  // Odd word first, even word after it, both buses of a channel
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      last <= 1'b0;
      got <= 1'b0;
    end
    else
    begin
      last <= fwd_clk;
      got <= latch;
      if (latch)
      begin
        pair_i <= {odd_i, even_i};
        pair_q <= {odd_q, even_q};
      end
    end
  end
endmodule // aodf_rx_model

/* verification/tb_adc_output_demux_formatter.sv */
// Testbench for the output demultiplexer and formatter
`timescale 1ns/100ps

module tb_adc_output_demux_formatter;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg sample_clock = 1'b1;
  reg [7:0] code_i = 8'h01;
  reg edge_sel = 1'b1;
  reg ddr = 1'b0;
  reg shut_i = 1'b0;
  reg shut_q = 1'b0;
  reg stall = 1'b0;
  reg lastf;
  reg [7:0] o;
  reg [7:0] e;
  wire [7:0] code_q = ~code_i;
  wire ready, cap_rdy, i_oe_n, q_oe_n, fwd, got;
  wire [7:0] odd_i, even_i, odd_q, even_q;
  wire [15:0] pair_i, pair_q;
  integer errors = 0;
  integer samples_checked = 0;
  integer m = 0;
  integer n;
  integer g;

  always #25 clk = ~clk;
  always #200 sample_clock = ~sample_clock;
  // Sample counter since reset; code set mid-period, far from capture
  always @(negedge sample_clock) if (!reset) m = m + 1;
  always @(posedge sample_clock) code_i <= m + 1;

  aodf_output_formatter i_dut (.clk(clk), .reset(reset),
    .sample_clock(sample_clock), .code_i(code_i), .code_q(code_q),
    .output_edge_select(edge_sel), .ddr_select(ddr),
    .shutdown_input_i(shut_i), .shutdown_input_q(shut_q),
    .receiver_ready(ready), .capture_ready(cap_rdy), .bus_odd_i(odd_i),
    .bus_even_i(even_i), .bus_odd_q(odd_q), .bus_even_q(even_q),
    .bus_i_oe_n(i_oe_n), .bus_q_oe_n(q_oe_n),
    .forwarded_output_clock(fwd));
  aodf_rx_model i_rx (.clk(clk), .reset(reset), .stall(stall),
    .fwd_clk(fwd), .edge_sel(edge_sel), .ddr(ddr), .odd_i(odd_i),
    .even_i(even_i), .odd_q(odd_q), .even_q(even_q), .ready(ready),
    .got(got), .pair_i(pair_i), .pair_q(pair_q));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string what, input [15:0] exp, input [15:0] seen);
    samples_checked = samples_checked + 1;
    if (exp !== seen)
    begin
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      errors = errors + 1;
    end
  endtask
  task wait_got;
    n = 0;
    @(negedge clk);
    while (got !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n = n + 1;
    end
    chk("pair arrival", 16'h1, {15'h0, got});
  endtask
  // Wait for the next pair update, seen as a change on the q even bus
  task wait_update;
    o = even_q;
    n = 0;
    while (even_q === o && n < 200)
    begin
      @(negedge clk);
      n = n + 1;
    end
    chk("bus update", 16'h1, {15'h0, even_q !== o});
  endtask
  task t_pairs(input integer k);
    repeat (k)
    begin
      wait_got;
      o = pair_i[15:8] ^ 8'h80;
      e = pair_i[7:0] ^ 8'h80;
      chk("odd bus parity", 16'h1, {15'h0, o[0]});
      chk("even after odd", {8'h0, o + 8'h01}, {8'h0, e});
      chk("q pair", {~o, ~e} ^ 16'h8080, pair_q);
    end
  endtask
  // Clock toggles and pair arrivals across forty sample periods
  task t_rate(input integer tog);
    n = 0;
    g = 0;
    lastf = fwd;
    repeat (320)
    begin
      @(negedge clk);
      n = n + (fwd !== lastf);
      g = g + got;
      lastf = fwd;
    end
    chk("clock rate", 16'h1, {15'h0, n >= tog - 1 && n <= tog + 1});
    chk("pair rate", 16'h1, {15'h0, g >= 19 && g <= 21});
  endtask
  // Straps change just after a pair update, never between its halves
  task t_sdr(input reg edge_v);
    wait_update;
    edge_sel = edge_v;
    t_pairs(3);
    e = pair_i[15:8];
    wait_got;
    chk("one bus decimated", {8'h0, e + 8'h02}, {8'h0, pair_i[15:8]});
    wait_update;
    chk("data edge", {15'h0, edge_v}, {15'h0, fwd});
    t_rate(40);
  endtask
  task t_ddr;
    wait_update;
    ddr = 1'b1;
    t_pairs(3);
    t_rate(20);
    wait_update;
    ddr = 1'b0;
  endtask
  // Receiver stalls until the buffer refuses, then drains
  task t_stall;
    stall = 1'b1;
    n = 0;
    while (cap_rdy !== 1'b0 && n < 400)
    begin
      @(negedge clk);
      n = n + 1;
    end
    chk("buffer full", 16'h0, {15'h0, cap_rdy});
    stall = 1'b0;
    t_pairs(3);
  endtask
  task t_shut;
    shut_i = 1'b1;
    shut_q = 1'b1;
    repeat (8) @(negedge clk);
    chk("i floats", 16'h1, {15'h0, i_oe_n});
    chk("q floats", 16'h1, {15'h0, q_oe_n});
    chk("i buses idle", 16'h0, {odd_i, even_i});
    shut_q = 1'b0;
    repeat (120) @(negedge clk);
    shut_i = 1'b0;
    while (i_oe_n !== 1'b0) @(negedge clk);
    n = 0;
    o = even_q;
    while (odd_i === 8'h00 && n < 100)
    begin
      @(negedge clk);
      if (even_q !== o) n = n + 1;
      o = even_q;
    end
    chk("flushed pairs", 16'd5, n[15:0]);
  endtask
  task wrap_up;
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge clk);
    chk("reset outputs", 16'h0, {odd_i, even_i ^ {7'h0, fwd}});
    chk("reset flags", 16'h2, {14'h0, cap_rdy, i_oe_n});
    reset = 1'b0;
    t_sdr(1'b1);
    t_sdr(1'b0);
    t_ddr;
    t_stall;
    t_shut;
    wrap_up;
  end
  // Whole run is a few thousand cycles; this bound catches a hang
  initial
  begin
    #2000000;
    errors = errors + 1;
    wrap_up;
  end
endmodule // tb_adc_output_demux_formatter
